// >>> core/rsp_params.svh
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH

// timing
`define RSP_CLK_HZ        10000000
`define RSP_MS_PER_S      1000
`define RSP_MS_CYCLES     (`RSP_CLK_HZ / `RSP_MS_PER_S)
`define RSP_OVERSAMPLE    16
`define RSP_CHAR_BITS     11
`define RSP_GAP_TICKS     (7 * `RSP_CHAR_BITS * `RSP_OVERSAMPLE / 2)
`define RSP_RATE_0        1200
`define RSP_RATE_1        2400
`define RSP_RATE_2        4800
`define RSP_RATE_3        9600
`define RSP_RATE_4        19200
`define RSP_RATE_5        38400

// register offsets (byte addresses) and buffer regions (address bits 7:6)
`define RSP_OFF_CONFIG    8'h00
`define RSP_OFF_DELAY     8'h04
`define RSP_OFF_CTRL      8'h08
`define RSP_OFF_STATUS    8'h0C
`define RSP_TXBUF_REGION  2'b01
`define RSP_RXBUF_REGION  2'b10

// field positions
`define RSP_CTRL_SEND     8
`define RSP_CTRL_DROP     9
`define RSP_ST_CRC_ERR    2
`define RSP_ST_PAR_ERR    3
`define RSP_ST_FRM_ERR    4

// reset values and limits
`define RSP_RST_STATION   8'h01
`define RSP_MAX_STATION   8'hFA
`define RSP_RST_RATE      3'h3
`define RSP_MAX_RATE      3'h5
`define RSP_RST_DELAY     7'h05
`define RSP_MIN_DELAY     7'h02
`define RSP_MAX_DELAY     7'h64
`define RSP_CRC_INIT      16'hFFFF
`define RSP_CRC_POLY      16'hA001
`define RSP_ASCII_END     8'h0D
`define RSP_MIN_FRAME     5'h04
`define RSP_BUF_DEPTH     16
`endif

// >>> core/rsp_pkg.sv
package rsp_pkg;
   typedef enum logic [1:0] {
      FMT_NONE_1, FMT_NONE_2, FMT_EVEN_1, FMT_ODD_1
   } rsp_fmt_type;

   typedef struct packed {
      logic [7:0]  station;
      logic        ascii;
      logic [2:0]  rate;
      rsp_fmt_type fmt;
   } rsp_cfg_type;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } rsp_apb_req_type;

   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rsp_rx_state_type;
   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} rsp_tx_state_type;
endpackage

// >>> core/rsp_tick_gen.sv
`include "rsp_params.svh"
module rsp_tick_gen
   import rsp_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [2:0] rate_i,
   output logic            tick_o
);
   function automatic logic [9:0] div_of(input logic [2:0] code);
      int rate;
      begin
         unique case (code)
            3'h0:    rate = `RSP_RATE_0;
            3'h1:    rate = `RSP_RATE_1;
            3'h2:    rate = `RSP_RATE_2;
            3'h4:    rate = `RSP_RATE_4;
            3'h5:    rate = `RSP_RATE_5;
            default: rate = `RSP_RATE_3;
         endcase
         // rounded to the nearest whole cycle
         return 10'((`RSP_CLK_HZ + rate * `RSP_OVERSAMPLE / 2) / (rate * `RSP_OVERSAMPLE));
      end
   endfunction

   logic [9:0] cnt;
   wire  [9:0] div_end = div_of(rate_i) - 10'h001;

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || cnt >= div_end)
         cnt <= 10'h000;
      else
         cnt <= cnt + 10'h001;
      tick_o <= !sys_rst_i && cnt >= div_end;
   end
endmodule // rsp_tick_gen

// >>> core/rsp_top.sv
`include "rsp_params.svh"
module rsp_top
   import rsp_pkg::*;
#(
   parameter int MS_CYCLES = `RSP_MS_CYCLES
)
(
   input  wire logic            ref_clk_i,
   input  wire logic            sys_rst_i,
   input  wire rsp_apb_req_type apb_i,
   output logic [31:0]          prdata_o,
   output logic                 pready_o,
   output logic                 pslverr_o,
   input  wire logic            rx_i,
   output logic                 tx_o,
   output logic                 tx_oe_o
);
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      begin
         r = c ^ {8'h00, d};
         for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `RSP_CRC_POLY) : (r >> 1);
         return r;
      end
   endfunction

   function automatic logic in_region(input logic [7:0] a, input logic [1:0] reg_id);
      return a[7:6] == reg_id;
   endfunction

   rsp_cfg_type cfg;
   logic [6:0]  resp_ms;
   logic [7:0]  tx_mem [`RSP_BUF_DEPTH];
   logic [7:0]  rx_mem [`RSP_BUF_DEPTH];
   logic        rx_s1, rx_s2;
   logic        tick;

   // two flops ahead of any use of the line
   always_ff @(posedge ref_clk_i)
   begin
      rx_s1 <= sys_rst_i ? 1'b1 : rx_i;
      rx_s2 <= sys_rst_i ? 1'b1 : rx_s1;
   end

   rsp_tick_gen u_tick (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .rate_i    (cfg.rate),
      .tick_o    (tick)
   );

   wire has_par = cfg.fmt == FMT_EVEN_1 || cfg.fmt == FMT_ODD_1;

   // receiver
   rsp_rx_state_type rx_st;
   logic [3:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   logic       rx_perr, rx_pbit, byte_done;
   always_ff @(posedge ref_clk_i)
   begin
      byte_done <= 1'b0;
      if (sys_rst_i)
      begin
         rx_st <= RX_IDLE;
         rx_cnt <= 4'h0;
      end
      else if (tick)
      begin
         rx_cnt <= rx_cnt + 4'h1;
         unique case (rx_st)
            RX_IDLE:  if (!rx_s2) begin rx_st <= RX_START; rx_cnt <= 4'h0; end
            RX_START: if (rx_cnt == 4'h7)
                         begin rx_cnt <= 4'h0; rx_bit <= 3'h0;
                            rx_st <= rx_s2 ? RX_IDLE : RX_DATA; end
            RX_DATA:  if (rx_cnt == 4'hF)
                         begin rx_sh <= {rx_s2, rx_sh[7:1]}; rx_bit <= rx_bit + 3'h1;
                            if (rx_bit == 3'h7) rx_st <= has_par ? RX_PAR : RX_STOP; end
            RX_PAR:   if (rx_cnt == 4'hF)
                         begin rx_pbit <= rx_s2; rx_st <= RX_STOP; end
            RX_STOP:  if (rx_cnt == 4'hF)
                         begin byte_done <= 1'b1; rx_st <= RX_IDLE;
                            rx_perr <= rx_s2 ? 1'b0 : 1'b1; end
         endcase
      end
   end
   // rx_perr here marks a missing stop bit; parity is judged below
   wire par_bad  = has_par && ((^rx_sh) ^ rx_pbit ^ (cfg.fmt == FMT_ODD_1));
   wire stop_bad = rx_perr;

   // frame assembly
   logic [4:0]  rx_len;
   logic [15:0] rx_crc;
   logic        fr_perr, fr_ferr, req_pending, tx_busy;
   logic        req_done;
   logic [9:0]  gap_cnt;
   logic        crc_err, par_err, frm_err;
   wire listen     = !req_pending && !tx_busy;
   wire take_byte  = byte_done && listen;
   wire ascii_end  = take_byte && cfg.ascii && rx_sh == `RSP_ASCII_END;
   wire gap_end    = !cfg.ascii && rx_len != 5'h00 && gap_cnt == 10'(`RSP_GAP_TICKS);
   wire frame_end  = listen && (ascii_end || gap_end);
   wire [4:0]  end_len = ascii_end ? rx_len + 5'h01 : rx_len;
   wire [15:0] end_crc = ascii_end ? crc_step(rx_crc, rx_sh) : rx_crc;
   wire end_perr   = fr_perr || (ascii_end && par_bad);
   wire end_ferr   = fr_ferr || (ascii_end && stop_bad) || end_len > 5'(`RSP_BUF_DEPTH);
   wire crc_bad    = end_crc != 16'h0000 || end_len < `RSP_MIN_FRAME;
   wire frame_ok   = frame_end && !crc_bad && !end_perr && !end_ferr;
   wire for_us     = rx_mem[0] == cfg.station;
   wire accept     = frame_ok && for_us;

   always_ff @(posedge ref_clk_i)
   begin
      // a finished or dropped request must not leave a stale frame to end again
      if (sys_rst_i || (frame_end && !accept) || (!listen && !req_pending) || req_done)
      begin
         rx_len <= 5'h00;
         rx_crc <= `RSP_CRC_INIT;
         fr_perr <= 1'b0;
         fr_ferr <= 1'b0;
      end
      else if (take_byte && !ascii_end)
      begin
         if (rx_len < 5'(`RSP_BUF_DEPTH))
            rx_mem[rx_len[3:0]] <= rx_sh;
         rx_len <= (rx_len > 5'(`RSP_BUF_DEPTH)) ? rx_len : rx_len + 5'h01;
         rx_crc <= crc_step(rx_crc, rx_sh);
         fr_perr <= fr_perr || par_bad;
         fr_ferr <= fr_ferr || stop_bad;
      end
      else if (accept)
         rx_len <= end_len;
      if (sys_rst_i || byte_done || rx_st != RX_IDLE)
         gap_cnt <= 10'h000;
      else if (tick && gap_cnt != 10'(`RSP_GAP_TICKS))
         gap_cnt <= gap_cnt + 10'h001;
   end

   // answer delay, counted from the accepted request
   logic [13:0] ms_cnt;
   logic [6:0]  dly_ms;
   wire dly_done = dly_ms >= resp_ms;
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || accept)
      begin
         ms_cnt <= 14'h0000;
         dly_ms <= 7'h00;
      end
      else if (ms_cnt == 14'(MS_CYCLES - 1))
      begin
         ms_cnt <= 14'h0000;
         dly_ms <= (dly_ms == 7'h7F) ? dly_ms : dly_ms + 7'h01;
      end
      else
         ms_cnt <= ms_cnt + 14'h0001;
   end

   // apb slave, one wait state
   wire        acc      = apb_i.psel && apb_i.penable && pready_o;
   wire        wr       = acc && apb_i.pwrite;
   wire [7:0]  a        = apb_i.paddr;
   wire        a_tx     = in_region(a, `RSP_TXBUF_REGION);
   wire        a_rx     = in_region(a, `RSP_RXBUF_REGION);
   wire        a_hit    = a_tx || a_rx || a == `RSP_OFF_CONFIG || a == `RSP_OFF_DELAY
                          || a == `RSP_OFF_CTRL || a == `RSP_OFF_STATUS;
   wire        bad_addr = a[1:0] != 2'b00 || !a_hit;
   wire [31:0] w        = apb_i.pwdata;
   wire        wr_cfg   = wr && !bad_addr && a == `RSP_OFF_CONFIG;
   wire        wr_ctrl  = wr && !bad_addr && a == `RSP_OFF_CTRL;
   wire        wr_stat  = wr && !bad_addr && a == `RSP_OFF_STATUS;
   wire [31:0] status   = {19'h0, rx_len, 3'h0, frm_err, par_err, crc_err, tx_busy, req_pending};
   wire [31:0] rd_val   =
      (a == `RSP_OFF_CONFIG) ? {18'h0, cfg.fmt, cfg.rate, cfg.ascii, cfg.station} :
      (a == `RSP_OFF_DELAY)  ? {25'h0, resp_ms} :
      (a == `RSP_OFF_STATUS) ? status :
      a_tx ? {24'h0, tx_mem[a[5:2]]} :
      a_rx ? {24'h0, rx_mem[a[5:2]]} : 32'h0000_0000;

   always_ff @(posedge ref_clk_i)
   begin
      pready_o  <= !sys_rst_i && apb_i.psel && apb_i.penable && !pready_o;
      pslverr_o <= !sys_rst_i && apb_i.psel && apb_i.penable && !pready_o && bad_addr;
      prdata_o  <= (sys_rst_i || bad_addr) ? 32'h0000_0000 : rd_val;
      if (sys_rst_i)
      begin
         cfg     <= '{station: `RSP_RST_STATION, ascii: 1'b0, rate: `RSP_RST_RATE,
                      fmt: FMT_NONE_1};
         resp_ms <= `RSP_RST_DELAY;
      end
      else
      begin
         // out-of-range settings keep the previous value
         if (wr_cfg && w[7:0] != 8'h00 && w[7:0] <= `RSP_MAX_STATION)
            cfg.station <= w[7:0];
         if (wr_cfg)
            cfg.ascii <= w[8];
         if (wr_cfg && w[11:9] <= `RSP_MAX_RATE)
            cfg.rate <= w[11:9];
         if (wr_cfg)
            cfg.fmt <= rsp_fmt_type'(w[13:12]);
         if (wr && !bad_addr && a == `RSP_OFF_DELAY
             && w[6:0] >= `RSP_MIN_DELAY && w[6:0] <= `RSP_MAX_DELAY)
            resp_ms <= w[6:0];
         if (wr && a_tx && !bad_addr)
            tx_mem[a[5:2]] <= w[7:0];
      end
   end

   // error flags: a new error wins over a clear in the same cycle
   wire bad_frame = frame_end && !frame_ok;
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         crc_err <= 1'b0;
         par_err <= 1'b0;
         frm_err <= 1'b0;
      end
      else
      begin
         crc_err <= (bad_frame && crc_bad) || (crc_err && !(wr_stat && w[`RSP_ST_CRC_ERR]));
         par_err <= (bad_frame && end_perr) || (par_err && !(wr_stat && w[`RSP_ST_PAR_ERR]));
         frm_err <= (bad_frame && end_ferr) || (frm_err && !(wr_stat && w[`RSP_ST_FRM_ERR]));
      end
   end

   // transmitter
   rsp_tx_state_type tx_st;
   logic [3:0]  tx_cnt;
   logic [2:0]  tx_bit;
   logic [7:0]  tx_sh;
   logic [4:0]  tx_len, tx_idx;
   logic [15:0] tx_crc;
   logic        tx_armed, tx_stop2;
   logic [7:0]  tx_sh_orig;
   // send is refused unless a request is waiting for its answer
   wire send_ok  = wr_ctrl && w[`RSP_CTRL_SEND] && req_pending && !tx_armed;
   wire go       = tx_armed && !tx_busy && dly_done && tick;
   wire [4:0] total  = tx_len + 5'h02;
   wire [7:0] next_byte = (tx_idx < tx_len) ? tx_mem[tx_idx[3:0]] :
                          (tx_idx == tx_len) ? tx_crc[7:0] : tx_crc[15:8];
   wire bit_end  = tick && tx_cnt == 4'hF;
   wire char_end = tx_st == TX_STOP && bit_end && !(cfg.fmt == FMT_NONE_2 && !tx_stop2);
   wire last     = char_end && tx_idx == total;
   assign req_done = last || (wr_ctrl && w[`RSP_CTRL_DROP] && !tx_armed);

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         tx_st <= TX_IDLE;
         tx_busy <= 1'b0;
         tx_armed <= 1'b0;
         req_pending <= 1'b0;
         tx_o <= 1'b1;
         tx_oe_o <= 1'b0;
         tx_cnt <= 4'h0;
      end
      else
      begin
         if (accept)
            req_pending <= 1'b1;
         else if (req_done)
            req_pending <= 1'b0;
         if (send_ok)
         begin
            tx_armed <= 1'b1;
            tx_len <= (w[4:0] > 5'(`RSP_BUF_DEPTH)) ? 5'(`RSP_BUF_DEPTH) : w[4:0];
         end
         if (tick)
            tx_cnt <= tx_cnt + 4'h1;
         if (go || (char_end && !last))
         begin
            tx_busy <= 1'b1;
            tx_oe_o <= 1'b1;
            tx_o <= 1'b0;
            tx_st <= TX_START;
            tx_cnt <= 4'h0;
            tx_sh <= go ? tx_mem[0] : next_byte;
            tx_idx <= go ? 5'h01 : tx_idx + 5'h01;
            // the check bytes themselves stay out of the sum
            if (go)
               tx_crc <= crc_step(`RSP_CRC_INIT, tx_mem[0]);
            else if (tx_idx < tx_len)
               tx_crc <= crc_step(tx_crc, next_byte);
            tx_stop2 <= 1'b0;
         end
         else if (last)
         begin
            // driver released right after the final stop bit
            tx_st <= TX_IDLE;
            tx_busy <= 1'b0;
            tx_armed <= 1'b0;
            tx_oe_o <= 1'b0;
            tx_o <= 1'b1;
         end
         else if (bit_end)
         begin
            unique case (tx_st)
               TX_IDLE:  tx_o <= 1'b1;
               TX_START: begin tx_st <= TX_DATA; tx_bit <= 3'h0; tx_o <= tx_sh[0]; end
               TX_DATA:  begin
                            tx_sh <= {1'b0, tx_sh[7:1]};
                            tx_bit <= tx_bit + 3'h1;
                            if (tx_bit == 3'h7)
                            begin
                               tx_st <= has_par ? TX_PAR : TX_STOP;
                               tx_o <= has_par ? (^tx_sh_orig) ^ (cfg.fmt == FMT_ODD_1) : 1'b1;
                            end
                            else
                               tx_o <= tx_sh[1];
                         end
               TX_PAR:   begin tx_st <= TX_STOP; tx_o <= 1'b1; end
               TX_STOP:  tx_stop2 <= 1'b1;
            endcase
         end
      end
   end

   // parity taken over the whole byte, kept while the shifter drains
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         tx_sh_orig <= 8'h00;
      else if (go || (char_end && !last))
         tx_sh_orig <= go ? tx_mem[0] : next_byte;
   end
endmodule // rsp_top

// >>> dv/rs485_slave_serial_port_bench.sv
module rs485_slave_serial_port_bench
   import rsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MS = 20;
   logic            ref_clk_i;
   logic            sys_rst_i;
   rsp_apb_req_type apb;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            line;
   logic            tx;
   logic            tx_oe;
   logic [31:0]     rd;
   logic            last_err;
   logic [7:0]      req[$];
   logic [7:0]      rep[$] = '{8'h83, 8'h5A};
   logic [15:0]     crc;
   int              t0;
   int              n_errors = 0;
   int              checks = 0;
   logic [7:0]      stn[4] = '{8'h00, 8'hFA, 8'hFB, 8'h07};
   logic [7:0]      stn_exp[4] = '{8'h07, 8'hFA, 8'hFA, 8'h07};
   logic [6:0]      dly[4] = '{7'h01, 7'h02, 7'h65, 7'h64};
   logic [6:0]      dly_exp[4] = '{7'h05, 7'h02, 7'h02, 7'h64};
   logic [1:0]      fk[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
   logic [31:0]     st_mask[4] = '{32'h0000_001D, 32'h0000_001D, 32'h0000_001D, 32'h0000_1F1D};
   logic [31:0]     st_exp[4] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_0001, 32'h0000_0401};

   rsp_top #(.MS_CYCLES(MS)) i_dut (.ref_clk_i, .sys_rst_i, .apb_i(apb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .rx_i(line), .tx_o(tx), .tx_oe_o(tx_oe));
   rsp_master_model i_master (.ref_clk_i, .line_i(tx), .line_en_i(tx_oe), .line_o(line));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      apb <= '{1'b1, 1'b0, wr, a, d};
      @(posedge ref_clk_i);
      apb.penable <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      last_err = pslverr;
      if (n >= 20)
         check("pready", 32'h0, 32'h1);
      apb <= '0;
      @(posedge ref_clk_i);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string what);
      xfer(1'b0, a, 32'h0000_0000);
      check(what, rd & m, e);
   endtask

   task automatic wait_oe(input logic lvl, input int lim);
      t0 = 0;
      while (tx_oe !== lvl && t0 < lim)
      begin
         @(posedge ref_clk_i);
         t0++;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // a clean run needs about 96k cycles
   initial
   begin
      repeat (100000) @(posedge ref_clk_i);
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      sys_rst_i = 1'b1;
      apb = '0;
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd_chk(8'h00, 32'h0000_3FFF, 32'h0000_0601, "config");
      rd_chk(8'h04, 32'h0000_007F, 32'h0000_0005, "delay");
      rd_chk(8'h0C, 32'h0000_001F, 32'h0000_0000, "status");
      check("mapped err", {31'h0, last_err}, 32'h0);
      rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
      check("unmapped err", {31'h0, last_err}, 32'h1);
      for (int r = 0; r < 7; r++)
      begin
         xfer(1'b1, 8'h00, 32'((r << 9) | 7));
         rd_chk(8'h00, 32'h0000_0E00, 32'((r > 5 ? 5 : r) << 9), "rate");
      end
      foreach (stn[i])
      begin
         xfer(1'b1, 8'h00, 32'h0000_0A00 | {24'h0, stn[i]});
         rd_chk(8'h00, 32'h0000_00FF, {24'h0, stn_exp[i]}, "station");
      end
      xfer(1'b1, 8'h00, 32'h0000_0B07);
      rd_chk(8'h00, 32'h0000_0100, 32'h0000_0100, "protocol");
      foreach (dly[i])
      begin
         xfer(1'b1, 8'h04, {25'h0, dly[i]});
         rd_chk(8'h04, 32'h0000_007F, {25'h0, dly_exp[i]}, "answer delay");
      end
      foreach (rep[i])
         xfer(1'b1, 8'h40 + 8'(4 * i), {24'h0, rep[i]});
      i_master.got.delete();
      // wrong station, bad check, good then dropped, good then answered
      for (int k = 0; k < 4; k++)
      begin
         xfer(1'b1, 8'h00, 32'h0000_0A07 | {18'h0, fk[k], 12'h000});
         i_master.fmt = rsp_fmt_type'(fk[k]);
         req = '{(k == 0) ? 8'h03 : 8'h07, 8'h03};
         i_master.send(req, k == 1);
         if (k < 3)
            repeat (10000) @(posedge ref_clk_i);
         else
         begin
            // arm at once, so the delay is timed from the accepted request
            t0 = 0;
            do
            begin
               xfer(1'b0, 8'h0C, 32'h0000_0000);
               t0++;
            end
            while (rd[0] !== 1'b1 && t0 < 3000);
            xfer(1'b1, 8'h08, 32'h0000_0102);
            wait_oe(1'b1, 3000);
            check("reply delay", {31'h0, t0 > 95 * MS && t0 < 105 * MS}, 32'h1);
         end
         rd_chk(8'h0C, st_mask[k], st_exp[k], "frame status");
         xfer(1'b1, 8'h0C, 32'h0000_001C);
         if (k == 2)
         begin
            xfer(1'b1, 8'h08, 32'h0000_0200);
            rd_chk(8'h0C, 32'h0000_0001, 32'h0000_0000, "dropped");
         end
      end
      rd_chk(8'h80, 32'h0000_00FF, 32'h0000_0007, "rx byte");
      wait_oe(1'b0, 20000);
      repeat (4) @(posedge ref_clk_i);
      crc = i_master.crc16(rep);
      rep.push_back(crc[7:0]);
      rep.push_back(crc[15:8]);
      check("reply size", 32'(i_master.got.size()), 32'h0000_0004);
      foreach (rep[i])
         check("reply byte", {24'h0, i_master.got[i]}, {24'h0, rep[i]});
      rd_chk(8'h0C, 32'h0000_0003, 32'h0000_0000, "after reply");
      report_and_stop();
   end
endmodule // rs485_slave_serial_port_bench

// >>> dv/rsp_master_model.sv
module rsp_master_model
   import rsp_pkg::*;
#(
   parameter int BIT = 256
)
(
   input  wire logic ref_clk_i,
   input  wire logic line_i,
   input  wire logic line_en_i,
   output logic      line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   rsp_fmt_type fmt = FMT_NONE_1;
   logic [7:0]  got[$];
   logic [7:0]  rx_byte;

   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction

   task automatic bit_out(input logic v);
      line_o <= v;
      repeat (BIT) @(posedge ref_clk_i);
   endtask

   // single slave on the segment, well inside sixteen
   task automatic send(input logic [7:0] q[$], input logic bad);
      logic [15:0] c;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      wait (!line_en_i);
      foreach (q[i])
      begin
         bit_out(1'b0);
         for (int b = 0; b < 8; b++)
            bit_out(q[i][b]);
         if (fmt inside {FMT_EVEN_1, FMT_ODD_1})
            bit_out(^q[i] ^ (fmt == FMT_ODD_1));
         bit_out(1'b1);
         if (fmt == FMT_NONE_2)
            bit_out(1'b1);
      end
   endtask

   // bias holds the released line high; stop bit not checked here
   initial
   begin
      line_o = 1'b1;
      forever
      begin
         @(negedge line_i iff line_en_i);
         repeat (BIT / 2) @(posedge ref_clk_i);
         for (int b = 0; b < 8; b++)
         begin
            repeat (BIT) @(posedge ref_clk_i);
            rx_byte[b] = line_i;
         end
         repeat (BIT * ((fmt inside {FMT_EVEN_1, FMT_ODD_1}) ? 2 : 1)) @(posedge ref_clk_i);
         got.push_back(rx_byte);
      end
   end
endmodule // rsp_master_model

// >>> dv/rsp_top_asserts.sv
module rsp_top_asserts
   import rsp_pkg::*;
#(
   parameter int MS_CYCLES = 10000
)
(
   input wire logic            ref_clk_i,
   input wire logic            sys_rst_i,
   input wire rsp_apb_req_type apb_i,
   input wire logic [31:0]     prdata_o,
   input wire logic            pready_o,
   input wire logic            pslverr_o,
   input wire logic            rx_i,
   input wire logic            tx_o,
   input wire logic            tx_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] quiet_cnt;
   logic        seen_req;
   wire  [7:0]  addr     = apb_i.paddr;
   wire         bad_addr = (addr[1:0] != 2'b00) || (addr[7:6] == 2'b11)
                           || (addr[7:6] == 2'b00 && addr[5:4] != 2'b00);

   // quiet time since the master last drove a low bit
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || !rx_i)
         quiet_cnt <= 16'h0000;
      else if (quiet_cnt != 16'hFFFF)
         quiet_cnt <= quiet_cnt + 16'h0001;
   end

   // weak on purpose: a dropped request still counts as a cause
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i || $fell(tx_oe_o))
         seen_req <= 1'b0;
      else if (!rx_i)
         seen_req <= 1'b1;
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence apb_setup_s;
      apb_i.psel && !apb_i.penable;
   endsequence
   sequence one_wait_s;
      !pready_o ##1 pready_o;
   endsequence

   ready_timing_a: assert property (apb_setup_s |=> one_wait_s)
      else $error("ready not after one wait state");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   ready_access_a: assert property (pready_o |-> apb_i.psel && apb_i.penable)
      else $error("ready outside access");
   err_decode_a: assert property (pready_o |-> pslverr_o == bad_addr)
      else $error("slave error does not follow decode");
   err_data_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0000_0000)
      else $error("data on refused access");
   tx_idle_a: assert property (!tx_oe_o |-> tx_o)
      else $error("line not idle high when released");
   tx_start_a: assert property ($rose(tx_oe_o) |-> !tx_o)
      else $error("reply does not open with start bit");
   tx_stop_a: assert property ($fell(tx_oe_o) |-> $past(tx_o))
      else $error("driver released before stop bit");
   no_overtalk_a: assert property (!rx_i |-> !tx_oe_o)
      else $error("driving while master sends");
   reply_wait_a: assert property ($rose(tx_oe_o) |-> int'(quiet_cnt) >= 2 * MS_CYCLES)
      else $error("reply before minimum delay");
   reply_cause_a: assert property ($rose(tx_oe_o) |-> seen_req)
      else $error("reply without request");
   reset_idle_a: assert property ($fell(sys_rst_i) |-> tx_o && !tx_oe_o && !pready_o)
      else $error("outputs not idle after reset");
endmodule // rsp_top_asserts

bind rsp_top rsp_top_asserts #(.MS_CYCLES(MS_CYCLES)) i_asserts (
   .ref_clk_i, .sys_rst_i, .apb_i, .prdata_o, .pready_o, .pslverr_o, .rx_i, .tx_o, .tx_oe_o);
